//--- src/pdpc_pkg.sv
// Purpose: shared constants for the divider, delay and pump configuration block
// Assumes: apb register index times four gives the byte address
// Notes: field positions follow the register layout of the loop

package pdpc_pkg;
	// register indices and byte addresses
	localparam logic [3:0] REG0_IDX      = 4'h0;
	localparam logic [3:0] REG2_IDX      = 4'h2;
	localparam logic [3:0] REG10_IDX     = 4'hA;
	localparam logic [3:0] REG11_IDX     = 4'hB;
	localparam logic [3:0] CTRL_IDX      = 4'hC;
	localparam logic [3:0] STAT_IDX      = 4'hD;
	localparam logic [7:0] PUMP_ADDR     = {2'h0, REG0_IDX, 2'h0};
	localparam logic [7:0] DELAY_ADDR    = {2'h0, REG2_IDX, 2'h0};
	localparam logic [7:0] DIVIDER_ADDR  = {2'h0, REG10_IDX, 2'h0};
	localparam logic [7:0] PRESCALE_ADDR = {2'h0, REG11_IDX, 2'h0};
	localparam logic [7:0] CTRL_ADDR     = {2'h0, CTRL_IDX, 2'h0};
	localparam logic [7:0] STAT_ADDR     = {2'h0, STAT_IDX, 2'h0};

	// field positions
	localparam int PUMP_CODE_LSB   = 14;
	localparam int PUMP_CODE_W     = 4;
	localparam int PUMP_PRESET_BIT = 13;
	localparam int DELAY_W         = 3;
	localparam int REF_DELAY_LSB   = 3;
	localparam int FB_DELAY_LSB    = 0;
	localparam int DIV_W           = 14;
	localparam int REF_DIV_LSB     = 0;
	localparam int FB_DIV_LSB      = 14;
	localparam int PRESCALE_LSB    = 5;
	localparam int PRESCALE_W      = 7;

	// reset values
	localparam logic [3:0]  PUMP_CODE_RST    = 4'hB;
	localparam logic        PUMP_PRESET_RST  = 1'b1;
	localparam logic [2:0]  DELAY_RST        = 3'h0;
	localparam logic [13:0] REF_DIV_RST      = 14'h007C;
	localparam logic [13:0] FB_DIV_RST       = 14'h02FF;
	localparam logic [6:0]  PRESCALE_RST     = 7'h20;
	localparam logic        REF_HALVE_RST    = 1'b0;

	// prescaler code classes
	localparam logic [6:0]  PRESCALE_UNITY   = 7'h20;
	localparam logic [4:0]  PRESCALE_LOW_TAG = 5'h10;
endpackage

//--- src/pdpc_divider.sv
// Purpose: programmable divider of an enable pulse stream
// Assumes: i_ratio_m1 is the ratio minus one
// Notes: one output pulse per ratio input pulses

`timescale 1ns/1ps
`default_nettype none

module pdpc_divider #(
	parameter int W = 14
) (
	input  wire logic         i_clock,
	input  wire logic         i_srst,
	input  wire logic         i_en,
	input  wire logic [W-1:0] i_ratio_m1,
	output logic              o_pulse
);
	logic [W-1:0] count_q;

	// counts input pulses, wraps at the ratio
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			count_q <= '0;
		end else if (i_en) begin
			if (count_q >= i_ratio_m1) begin
				count_q <= '0;
			end else begin
				count_q <= count_q + 1'b1;
			end
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_pulse <= 1'b0;
		end else begin
			o_pulse <= i_en && (count_q >= i_ratio_m1);
		end
	end
endmodule

`default_nettype wire

//--- src/pdpc_top.sv
// Purpose: divider, delay select and charge pump configuration of the loop
// Assumes: reference and oscillator clocks arrive as pins sampled at 100 MHz
// Notes: delays and pump current are analog; selects leave as ports
//
// Overview of operation
// - decode prescaler codes to ratios 1 to 80
// - three-bit delay selects for both paths
// - reference delay lags outputs, feedback delay leads
// - reference and feedback divider codes, 14 bits each
// - each divider divides by code plus one
// - defaults give reference 125, feedback 768
// - four-bit pump current code, zero tri-states
// - pump pulses follow phase detector decisions
// - preset bit forces pump to half supply
// - phase detector compares both divided clocks

`timescale 1ns/1ps
`default_nettype none

module pdpc_top (
	input  wire logic        i_clock,
	input  wire logic        i_srst,
	input  wire logic        i_psel,
	input  wire logic        i_penable,
	input  wire logic        i_pwrite,
	input  wire logic [7:0]  i_paddr,
	input  wire logic [31:0] i_pwdata,
	output logic [31:0]      o_prdata,
	output logic             o_pready,
	output logic             o_pslverr,
	input  wire logic        i_ref_clk,
	input  wire logic        i_osc_clk,
	output logic             o_pump_up,
	output logic             o_pump_down,
	output logic             o_pump_tristate,
	output logic [3:0]       o_pump_current_code,
	output logic             o_pump_midsupply_preset,
	output logic [2:0]       o_ref_path_delay_select,
	output logic [2:0]       o_fb_path_delay_select,
	output logic             o_ref_div_pulse,
	output logic             o_fb_div_pulse
);
	logic [3:0]  pump_current_code_q;
	logic        pump_midsupply_preset_q;
	logic [2:0]  ref_path_delay_select_q;
	logic [2:0]  fb_path_delay_select_q;
	logic [13:0] ref_div_code_q;
	logic [13:0] fb_div_code_q;
	logic [6:0]  prescale_code_q;
	logic        ref_halve_q;
	logic        wr_en;
	logic        rd_setup;
	logic        addr_ok;
	logic [31:0] rd_data;
	logic [2:0]  ref_sync_q;
	logic [2:0]  osc_sync_q;
	logic        ref_edge;
	logic        osc_edge;
	logic [6:0]  prescale_m1;
	logic        prescale_pulse;
	logic        ref_pre_pulse;
	logic        ref_div_pulse;
	logic        fb_div_pulse;
	logic        up_q;
	logic        down_q;

	// apb decode, zero wait states
	assign o_pready = 1'b1;
	assign addr_ok  = (i_paddr == pdpc_pkg::PUMP_ADDR) || (i_paddr == pdpc_pkg::DELAY_ADDR) ||
		(i_paddr == pdpc_pkg::DIVIDER_ADDR) || (i_paddr == pdpc_pkg::PRESCALE_ADDR) ||
		(i_paddr == pdpc_pkg::CTRL_ADDR) || (i_paddr == pdpc_pkg::STAT_ADDR);
	assign o_pslverr = i_psel && i_penable && !addr_ok;
	assign wr_en     = i_psel && i_penable && i_pwrite && addr_ok;
	assign rd_setup  = i_psel && !i_penable && !i_pwrite;

	// pump configuration register
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			pump_current_code_q     <= pdpc_pkg::PUMP_CODE_RST;
			pump_midsupply_preset_q <= pdpc_pkg::PUMP_PRESET_RST;
		end else if (wr_en && i_paddr == pdpc_pkg::PUMP_ADDR) begin
			pump_current_code_q     <= i_pwdata[pdpc_pkg::PUMP_CODE_LSB +: pdpc_pkg::PUMP_CODE_W];
			pump_midsupply_preset_q <= i_pwdata[pdpc_pkg::PUMP_PRESET_BIT];
		end
	end

	// delay select register
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			ref_path_delay_select_q <= pdpc_pkg::DELAY_RST;
			fb_path_delay_select_q  <= pdpc_pkg::DELAY_RST;
		end else if (wr_en && i_paddr == pdpc_pkg::DELAY_ADDR) begin
			ref_path_delay_select_q <= i_pwdata[pdpc_pkg::REF_DELAY_LSB +: pdpc_pkg::DELAY_W];
			fb_path_delay_select_q  <= i_pwdata[pdpc_pkg::FB_DELAY_LSB +: pdpc_pkg::DELAY_W];
		end
	end

	// divider code register
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			ref_div_code_q <= pdpc_pkg::REF_DIV_RST;
			fb_div_code_q  <= pdpc_pkg::FB_DIV_RST;
		end else if (wr_en && i_paddr == pdpc_pkg::DIVIDER_ADDR) begin
			ref_div_code_q <= i_pwdata[pdpc_pkg::REF_DIV_LSB +: pdpc_pkg::DIV_W];
			fb_div_code_q  <= i_pwdata[pdpc_pkg::FB_DIV_LSB +: pdpc_pkg::DIV_W];
		end
	end

	// prescaler code register
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			prescale_code_q <= pdpc_pkg::PRESCALE_RST;
		end else if (wr_en && i_paddr == pdpc_pkg::PRESCALE_ADDR) begin
			prescale_code_q <= i_pwdata[pdpc_pkg::PRESCALE_LSB +: pdpc_pkg::PRESCALE_W];
		end
	end

	// control register: reference prescaler one or two
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			ref_halve_q <= pdpc_pkg::REF_HALVE_RST;
		end else if (wr_en && i_paddr == pdpc_pkg::CTRL_ADDR) begin
			ref_halve_q <= i_pwdata[0];
		end
	end

	// read mux
	always_comb begin
		rd_data = 32'h0000_0000;
		unique case (i_paddr)
			pdpc_pkg::PUMP_ADDR: begin
				rd_data[pdpc_pkg::PUMP_CODE_LSB +: pdpc_pkg::PUMP_CODE_W] = pump_current_code_q;
				rd_data[pdpc_pkg::PUMP_PRESET_BIT] = pump_midsupply_preset_q;
			end
			pdpc_pkg::DELAY_ADDR: begin
				rd_data[pdpc_pkg::REF_DELAY_LSB +: pdpc_pkg::DELAY_W] = ref_path_delay_select_q;
				rd_data[pdpc_pkg::FB_DELAY_LSB +: pdpc_pkg::DELAY_W]  = fb_path_delay_select_q;
			end
			pdpc_pkg::DIVIDER_ADDR: begin
				rd_data[pdpc_pkg::REF_DIV_LSB +: pdpc_pkg::DIV_W] = ref_div_code_q;
				rd_data[pdpc_pkg::FB_DIV_LSB +: pdpc_pkg::DIV_W]  = fb_div_code_q;
			end
			pdpc_pkg::PRESCALE_ADDR: begin
				rd_data[pdpc_pkg::PRESCALE_LSB +: pdpc_pkg::PRESCALE_W] = prescale_code_q;
			end
			pdpc_pkg::CTRL_ADDR: begin
				rd_data[0] = ref_halve_q;
			end
			pdpc_pkg::STAT_ADDR: begin
				rd_data[0] = up_q;
				rd_data[1] = down_q;
				rd_data[2] = o_pump_tristate;
				rd_data[3] = pump_midsupply_preset_q;
			end
			default: begin
				rd_data = 32'h0000_0000;
			end
		endcase
	end

	// read data captured in setup, held through access
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			o_prdata <= 32'h0000_0000;
		end else if (rd_setup) begin
			o_prdata <= rd_data;
		end
	end

	// pin synchronisers with edge detect on the settled stages
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			ref_sync_q <= 3'h0;
			osc_sync_q <= 3'h0;
		end else begin
			ref_sync_q <= {ref_sync_q[1:0], i_ref_clk};
			osc_sync_q <= {osc_sync_q[1:0], i_osc_clk};
		end
	end
	assign ref_edge = ref_sync_q[1] && !ref_sync_q[2];
	assign osc_edge = osc_sync_q[1] && !osc_sync_q[2];

	// prescaler ratio minus one from its code
	always_comb begin
		prescale_m1 = 7'h00;
		if (prescale_code_q == pdpc_pkg::PRESCALE_UNITY) begin
			prescale_m1 = 7'h00;
		end else if (prescale_code_q[6:2] == pdpc_pkg::PRESCALE_LOW_TAG) begin
			prescale_m1 = {5'h00, prescale_code_q[1:0]} + 7'h01;
		end else if (prescale_code_q[6:5] == 2'h0) begin
			prescale_m1 = 7'((({4'h0, prescale_code_q[4:2]} + 7'h01) *
				({5'h00, prescale_code_q[1:0]} + 7'h02) * 7'h02) - 7'h01);
		end
	end

	pdpc_divider #(.W(7)) u_fb_prescale (
		.i_clock    (i_clock),
		.i_srst     (i_srst),
		.i_en       (osc_edge),
		.i_ratio_m1 (prescale_m1),
		.o_pulse    (prescale_pulse)
	);

	pdpc_divider #(.W(14)) u_fb_div (
		.i_clock    (i_clock),
		.i_srst     (i_srst),
		.i_en       (prescale_pulse),
		.i_ratio_m1 (fb_div_code_q),
		.o_pulse    (fb_div_pulse)
	);

	pdpc_divider #(.W(1)) u_ref_prescale (
		.i_clock    (i_clock),
		.i_srst     (i_srst),
		.i_en       (ref_edge),
		.i_ratio_m1 (ref_halve_q),
		.o_pulse    (ref_pre_pulse)
	);

	pdpc_divider #(.W(14)) u_ref_div (
		.i_clock    (i_clock),
		.i_srst     (i_srst),
		.i_en       (ref_pre_pulse),
		.i_ratio_m1 (ref_div_code_q),
		.o_pulse    (ref_div_pulse)
	);

	// phase detector: set on own edge, common reset in the cycle both would be set, so both are never high together
	always_ff @(posedge i_clock) begin
		if (i_srst) begin
			up_q   <= 1'b0;
			down_q <= 1'b0;
		end else if ((up_q || ref_div_pulse) && (down_q || fb_div_pulse)) begin
			up_q   <= 1'b0;
			down_q <= 1'b0;
		end else begin
			up_q   <= up_q || ref_div_pulse;
			down_q <= down_q || fb_div_pulse;
		end
	end

	// pump drive, gated by preset and zero current
	assign o_pump_tristate         = (pump_current_code_q == 4'h0) || pump_midsupply_preset_q;
	assign o_pump_up               = up_q && !o_pump_tristate;
	assign o_pump_down             = down_q && !o_pump_tristate;
	assign o_pump_current_code     = pump_current_code_q;
	assign o_pump_midsupply_preset = pump_midsupply_preset_q;
	assign o_ref_path_delay_select = ref_path_delay_select_q;
	assign o_fb_path_delay_select  = fb_path_delay_select_q;
	assign o_ref_div_pulse         = ref_div_pulse;
	assign o_fb_div_pulse          = fb_div_pulse;
endmodule

`default_nettype wire

//--- tb/pdpc_vcxo_model.sv
// Purpose: free-running oscillator that feeds the feedback pin
// Assumes: half period of at least two system clocks
// Notes: always drives, so the pin never floats

`timescale 1ns/1ps
`default_nettype none

module pdpc_vcxo_model #(
	parameter int HALF_NS = 30
) (
	output logic o_osc_clk
);
	// offset keeps edges clear of the system clock edge
	initial begin
		o_osc_clk = 1'b0;
		#3;
		forever #HALF_NS o_osc_clk = ~o_osc_clk;
	end
endmodule

`default_nettype wire

//--- tb/pdpc_top_chk.sv
// Purpose: port checks of the configuration block
// Assumes: zero wait state register bus
// Notes: bound into every pdpc_top

`timescale 1ns/1ps
`default_nettype none

module pdpc_top_chk (
	input wire logic        i_clock,
	input wire logic        i_srst,
	input wire logic        i_psel,
	input wire logic        i_penable,
	input wire logic        i_pwrite,
	input wire logic [7:0]  i_paddr,
	input wire logic [31:0] i_pwdata,
	input wire logic        o_pready,
	input wire logic        o_pslverr,
	input wire logic        o_pump_up,
	input wire logic        o_pump_down,
	input wire logic        o_pump_tristate,
	input wire logic [3:0]  o_pump_current_code,
	input wire logic        o_pump_midsupply_preset,
	input wire logic [2:0]  o_ref_path_delay_select,
	input wire logic [2:0]  o_fb_path_delay_select,
	input wire logic        o_ref_div_pulse,
	input wire logic        o_fb_div_pulse
);
	logic hit;
	logic wr;
	assign hit = i_paddr inside {8'h00, 8'h08, 8'h28, 8'h2C, 8'h30, 8'h34};
	assign wr = i_psel && i_penable && i_pwrite;
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (i_srst);
	bus_ready_a: assert property (o_pready) else $error("pready low");
	bus_error_a: assert property (i_psel && i_penable |-> o_pslverr == !hit)
		else $error("pslverr wrong");
	reset_load_a: assert property (disable iff (1'b0) i_srst |=>
		o_pump_current_code == 4'hB && o_pump_midsupply_preset && o_ref_path_delay_select == 3'h0)
		else $error("reset value wrong");
	pump_write_a: assert property (wr && i_paddr == 8'h00 |=>
		o_pump_current_code == $past(i_pwdata[17:14])
		&& o_pump_midsupply_preset == $past(i_pwdata[13])) else $error("pump write lost");
	delay_write_a: assert property (wr && i_paddr == 8'h08 |=>
		{o_ref_path_delay_select, o_fb_path_delay_select} == $past(i_pwdata[5:0]))
		else $error("delay write lost");
	pump_off_a: assert property (o_pump_tristate ==
		(o_pump_current_code == 4'h0 || o_pump_midsupply_preset)) else $error("tristate wrong");
	pump_gate_a: assert property (o_pump_tristate |-> !o_pump_up && !o_pump_down)
		else $error("pump active while off");
	pfd_clear_a: assert property ((o_pump_up || o_ref_div_pulse) &&
		(o_pump_down || o_fb_div_pulse) |=> !o_pump_up && !o_pump_down)
		else $error("pfd not cleared");
	pfd_excl_a: assert property (!(o_pump_up && o_pump_down))
		else $error("pfd both set");
	ref_pulse_a: assert property (o_ref_div_pulse |=> !o_ref_div_pulse)
		else $error("ref pulse long");
	fb_pulse_a: assert property (o_fb_div_pulse |=> !o_fb_div_pulse)
		else $error("fb pulse long");
endmodule

bind pdpc_top pdpc_top_chk u_chk (
	.i_clock                 (i_clock),
	.i_srst                  (i_srst),
	.i_psel                  (i_psel),
	.i_penable               (i_penable),
	.i_pwrite                (i_pwrite),
	.i_paddr                 (i_paddr),
	.i_pwdata                (i_pwdata),
	.o_pready                (o_pready),
	.o_pslverr               (o_pslverr),
	.o_pump_up               (o_pump_up),
	.o_pump_down             (o_pump_down),
	.o_pump_tristate         (o_pump_tristate),
	.o_pump_current_code     (o_pump_current_code),
	.o_pump_midsupply_preset (o_pump_midsupply_preset),
	.o_ref_path_delay_select (o_ref_path_delay_select),
	.o_fb_path_delay_select  (o_fb_path_delay_select),
	.o_ref_div_pulse         (o_ref_div_pulse),
	.o_fb_div_pulse          (o_fb_div_pulse)
);

`default_nettype wire

//--- tb/tb_pdpc_top.sv
// Purpose: register and divider tests of the configuration block
// Assumes: reference pin made here, period six clocks
// Notes: oscillator period six clocks

`timescale 1ns/1ps
`default_nettype none

module tb_pdpc_top;
	logic        clock = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0;
	logic        ref_clk = 1'b0, err, up, dn, tri_s, pre, rp, fp;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, q;
	logic [3:0]  code;
	logic [2:0]  rd_s, fd_s;
	logic [1:0]  ph = 2'h0;
	logic        rdy, osc;
	int          bad_count = 0, cmp_count = 0, n, i;
	int          t_ctl[5] = '{0, 1, 0, 0, 0}, t_div[5] = '{32'h4002, 32'h4002, 0, 0, 0};
	int          t_pre[5] = '{32'h20, 32'h43, 32'h05, 32'h50, 32'h00};
	int          t_r[5] = '{18, 36, 6, 6, 6}, t_f[5] = '{12, 60, 72, 6, 24};

	always #5 clock = ~clock;
	always @(posedge clock) begin
		ph <= (ph == 2'h2) ? 2'h0 : ph + 2'h1;
		if (ph == 2'h2) ref_clk <= ~ref_clk;
	end

	pdpc_vcxo_model u_osc (.o_osc_clk(osc));
	pdpc_top u_dut (.i_clock(clock), .i_srst(srst), .i_psel(psel), .i_penable(pen),
		.i_pwrite(pwr), .i_paddr(addr), .i_pwdata(wdata), .o_prdata(rdata), .o_pready(rdy),
		.o_pslverr(err), .i_ref_clk(ref_clk), .i_osc_clk(osc), .o_pump_up(up),
		.o_pump_down(dn), .o_pump_tristate(tri_s), .o_pump_current_code(code),
		.o_pump_midsupply_preset(pre), .o_ref_path_delay_select(rd_s),
		.o_fb_path_delay_select(fd_s), .o_ref_div_pulse(rp), .o_fb_div_pulse(fp));

	task automatic give_verdict();
		if (bad_count == 0 && cmp_count > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		cmp_count++;
		if (got !== exp) begin
			bad_count++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		psel  <= 1'b1;
		pwr   <= w;
		addr  <= a;
		wdata <= d;
		@(posedge clock);
		pen <= 1'b1;
		do @(posedge clock); while (rdy !== 1'b1);
		q = rdata;
		psel <= 1'b0;
		pen  <= 1'b0;
		@(posedge clock);
	endtask

	task automatic gap(input logic side, output int cnt);
		cnt = 0;
		repeat (2) begin
			cnt = 0;
			do @(posedge clock); while ((side ? rp : fp) !== 1'b1);
			do begin
				@(posedge clock);
				cnt++;
			end while ((side ? rp : fp) !== 1'b1);
		end
	endtask

	initial begin
		#300000;
		bad_count++;
		give_verdict();
	end

	initial begin
		repeat (6) @(posedge clock);
		srst <= 1'b0;
		apb(0, 8'h00, 0);
		cmp(q, 32'h0002E000);
		apb(0, 8'h28, 0);
		cmp(q, 32'h00BFC07C);
		apb(0, 8'h2C, 0);
		cmp(q, 32'h00000400);
		apb(0, 8'h40, 0);
		cmp(q, 0);
		for (i = 0; i < 8; i++) begin
			apb(1, 8'h08, i * 9 ^ 7);
			cmp({rd_s, fd_s}, i * 9 ^ 7);
		end
		for (i = 0; i < 5; i++) begin
			apb(1, 8'h30, t_ctl[i]);
			apb(1, 8'h28, t_div[i]);
			apb(1, 8'h2C, t_pre[i] << 5);
			gap(1, n);
			cmp(n, t_r[i]);
			gap(0, n);
			cmp(n, t_f[i]);
		end
		for (i = 0; i < 16; i++) begin
			apb(1, 8'h00, i << 14);
			cmp({tri_s, code}, {i == 0, 4'(i)});
		end
		apb(1, 8'h00, 32'h00016000);
		cmp({tri_s, pre}, 2'h3);
		apb(1, 8'h00, 32'h0002C000);
		n = 0;
		while (n < 100 && up !== 1'b1 && dn !== 1'b1) begin
			@(posedge clock);
			n++;
		end
		cmp(n < 100, 1);
		repeat (60) @(posedge clock);
		srst <= 1'b1;
		repeat (2) @(posedge clock);
		srst <= 1'b0;
		cmp({tri_s, pre, code, up, dn}, 8'hEC);
		apb(0, 8'h28, 0);
		cmp(q, 32'h00BFC07C);
		give_verdict();
	end
endmodule

`default_nettype wire
